// File: core/pmpu_top.sv
`timescale 1ns/1ps
// Function
// - Fault disables user map, pushes five words
// - Then jump through word three
// - Out-of-range read undefined, write silently dropped
// - Mapped effective-address mode turns I/O into load
// - Block load ignores effective-address mode
// - Power up unmapped, page 31 identity
// - I/O reset unmaps, stops channel, page 31
// - Mapped control ops other than block load need both protections off
// - Mapped single cycle unmaps after next reference
// - Protected block load faults, changes nothing
// - Ascending load, count down, address up
// - Table select field picks loaded table
// - Word holds protect, logical, physical fields
// - Protect plus all-ones physical means invalid
// - Channel references never fault
// - Next fetch uses freshly loaded translation
// - Status load copies accumulator, user select
// - Select codes A C B D, then channels
// - Bits 9-12 protections, bit 14 channel
// - User enable inhibits interrupts until trigger
// - Status read; reset clears listed bits
// - Sixteen-deep indirect chain faults when enabled
// - Write to protected page faults when enabled
// - Invalid user page faults, except in single cycle (no access)
// - Status records last fault cause
module pmpu_top import pmpu_pkg::*; (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire pmpu_cmd_s   i_cmd,       // Control instruction
  input  wire pmpu_ref_s   i_ref,       // Memory reference
  input  wire logic        i_ret_op,    // Return-type instruction seen
  input  wire logic [15:0] i_next_pc,   // Word after current instruction
  input  wire logic [15:0] i_sp,        // Stack pointer
  input  wire logic [63:0] i_acs,       // Accumulators 0-3, 0 high
  input  wire logic        i_mem_ack,   // Memory finished request
  input  wire logic [15:0] i_mem_rdata, // Read data with ack
  output pmpu_mem_s        o_mem,
  output pmpu_word_s       o_ac,        // Status read / page check
  output pmpu_bml_s        o_bml,
  output pmpu_word_s       o_jump,      // Handler address
  output logic             o_fault,
  output logic             o_lef_exec,
  output logic             o_irq_inhibit,
  output logic             o_busy
);
  typedef enum {S_IDLE, S_REF, S_PUSH, S_VEC, S_LOAD} pmpu_st_e;

  // Selection codes A=0 C=1 B=2 D=3, so pairs are swapped
  function automatic logic [2:0] pmpu_idx(input logic ch, input logic [1:0] s);
    return {ch, s[0], s[1]};
  endfunction : pmpu_idx

  pmpu_st_e    st_reg, st_next;           // Sequencer state
  logic [15:0] stat_reg, stat_next;       // Status register
  logic        xl_reg, xl_next;           // User translation on
  logic        uew_reg, uew_next;         // Waiting to start mapping
  logic        sc_reg, sc_next;           // Single cycle armed
  logic [9:0]  p31_reg, p31_next;         // Unmapped page 31 target
  logic [4:0]  chk_reg, chk_next;         // Page to check
  logic [3:0]  ind_reg, ind_next;         // Indirect chain depth
  logic [2:0]  wc_reg, wc_next;           // Words pushed
  logic [15:0] cnt_reg, cnt_next;         // Block load count
  logic [15:0] adr_reg, adr_next;         // Block load address
  logic [79:0] frm_reg, frm_next;         // Return block
  pmpu_mem_s   mem_reg, mem_next;
  pmpu_word_s  ac_reg, ac_next, jmp_reg, jmp_next;
  pmpu_bml_s   bml_reg, bml_next;
  logic        flt_reg, flt_next, lef_reg, lef_next;
  logic        irq_reg, irq_next, bsy_reg, bsy_next; // Registered level outputs
  logic [10:0] tbl [8][32];               // Protect + physical page
  logic        tw_en;
  logic [2:0]  tw_t;
  logic [4:0]  tw_p;
  logic [10:0] tw_d;
  logic        cmd_go;                    // Control op carried out
  logic [10:0] ent;
  logic [9:0]  pp;
  logic        inval, flt, cpu_map;
  logic [15:0] cause;

  // Next-state logic for the whole unit
  always_comb begin
    st_next = st_reg;  stat_next = stat_reg;  xl_next = xl_reg;
    uew_next = uew_reg;  sc_next = sc_reg;  p31_next = p31_reg;
    chk_next = chk_reg;  ind_next = ind_reg;  wc_next = wc_reg;
    cnt_next = cnt_reg;  adr_next = adr_reg;  frm_next = frm_reg;
    mem_next = mem_reg;  ac_next = '0;  jmp_next = '0;  bml_next = '0;
    flt_next = 1'b0;  lef_next = 1'b0;
    tw_en = 1'b0;  tw_t = stat_reg[ST_SELH:ST_SELL];
    tw_p = i_mem_rdata[TW_LPH:TW_LPL];
    tw_d = {i_mem_rdata[TW_WP], i_mem_rdata[9:0]};
    cmd_go = 1'b0;  flt = 1'b0;  cause = '0;
    cpu_map = xl_reg | sc_reg;
    // Pick the entry; user ordinal has printed bit 0 as high digit
    if (i_ref.chan)
      ent = tbl[pmpu_idx(1'b1, i_ref.chan_sel)][i_ref.addr[14:10]];
    else
      ent = tbl[pmpu_idx(1'b0, {stat_reg[ST_NME0], stat_reg[ST_NME1]})][i_ref.addr[14:10]];
    inval = ent[10] & (&ent[9:0]);
    if (i_ref.chan ? stat_reg[ST_DCH] : cpu_map)
      pp = ent[9:0];
    else if (i_ref.addr[14:10] == PAGE_31)
      pp = p31_reg;
    else
      pp = {5'h00, i_ref.addr[14:10]};
    unique case (st_reg)
      S_IDLE: begin
        if (i_cmd.valid) begin
          if (xl_reg && stat_reg[ST_LEF] && i_cmd.op != OP_BLOCK_LOAD)
            lef_next = 1'b1;
          else if (xl_reg && stat_reg[ST_IOP] && i_cmd.op != OP_NONE) begin
            flt = 1'b1;
            cause[ST_IOF] = 1'b1;
          end else begin
            cmd_go = 1'b1;
            unique case (i_cmd.op)
              OP_STATUS_LOAD: begin
                // Reserved 1-5 hold state and causes
                stat_next = {i_cmd.ac[15], stat_reg[14:10], i_cmd.ac[9:0]};
                uew_next = i_cmd.ac[ST_UE];
                if (!i_cmd.ac[ST_UE])
                  xl_next = 1'b0;
              end
              OP_STATUS_READ:
                ac_next = '{1'b1, {stat_reg[15], xl_reg, stat_reg[13:0]}};
              OP_INIT_CHECK: begin
                chk_next = i_cmd.ac[TW_LPH:TW_LPL];
                stat_next[ST_SELH:ST_SELL] = i_cmd.ac[ST_SELH:ST_SELL];
              end
              OP_PAGE_CHECK: begin
                ac_next.valid = 1'b1; // Tables untouched
                ac_next.data = {tbl[stat_reg[ST_SELH:ST_SELL]][chk_reg][10],
                                stat_reg[ST_SELH:ST_SELL], 2'b00,
                                tbl[stat_reg[ST_SELH:ST_SELL]][chk_reg][9:0]};
              end
              OP_PAGE31_SET:
                if (!xl_reg)
                  p31_next = i_cmd.ac[9:0];
              OP_SINGLE_CYCLE: begin
                sc_next = 1'b1;
                stat_next[ST_SC] = 1'b1;
              end
              OP_IO_RESET: begin
                stat_next = stat_reg & ST_IO_RESET_OP_KEEP;
                xl_next = 1'b0;
                uew_next = 1'b0;
                sc_next = 1'b0;
                p31_next = PPAGE_31;
              end
              OP_BLOCK_LOAD: begin
                cnt_next = i_cmd.ac1; // Source already resolved
                adr_next = i_cmd.ac2;
                st_next = S_LOAD;
              end
              default: ;
            endcase
          end
        end else if (i_ref.valid) begin
          // Faults only for mapped CPU references
          if (!i_ref.chan && cpu_map && !sc_reg) begin
            if (inval)
              flt = 1'b1;
            else if (i_ref.write && stat_reg[ST_WP] && ent[10]) begin
              flt = 1'b1;
              cause[ST_WPF] = 1'b1;
            end else if (i_ref.indirect && stat_reg[ST_IND] && ind_reg == IND_LAST) begin
              flt = 1'b1;
              cause[ST_INDF] = 1'b1;
            end
          end
          ind_next = i_ref.indirect ? ind_reg + 4'h1 : 4'h0;
          if (uew_reg && i_ref.indirect) begin
            uew_next = 1'b0;
            xl_next = 1'b1;
          end
          if (!flt) begin
            // Invalid single-cycle page or high write: no access
            mem_next.req = !(sc_reg && inval && !i_ref.chan) &&
                           !(i_ref.write && pp >= PPAGE_LIM);
            mem_next.we = i_ref.write;
            mem_next.addr = {pp, i_ref.addr[9:0]};
            mem_next.wdata = '0;
            st_next = mem_next.req ? S_REF : S_IDLE;
            if (!mem_next.req && sc_reg) begin
              sc_next = 1'b0;
              xl_next = 1'b0;
            end
          end
        end else if (i_ret_op && uew_reg) begin
          uew_next = 1'b0;
          xl_next = 1'b1;
        end
      end
      S_REF:
        if (i_mem_ack) begin
          mem_next.req = 1'b0;
          st_next = S_IDLE;
          if (sc_reg) begin
            sc_next = 1'b0;
            xl_next = 1'b0;
          end
        end
      S_PUSH:
        if (i_mem_ack) begin
          wc_next = wc_reg + 3'h1;
          frm_next = {frm_reg[63:0], 16'h0000};
          mem_next.addr = {4'h0, i_sp + {13'h0000, wc_reg} + 16'h0002};
          mem_next.wdata = frm_reg[79:64]; // Oldest unpushed word
          if (wc_reg + 3'h1 == RET_WORDS) begin
            mem_next = '{1'b1, 1'b0, FAULT_VEC, 16'h0000};
            st_next = S_VEC;
          end
        end
      S_VEC:
        if (i_mem_ack) begin
          mem_next.req = 1'b0;
          jmp_next = '{1'b1, i_mem_rdata};
          st_next = S_IDLE;
        end
      S_LOAD: begin
        if (mem_reg.req && i_mem_ack) begin
          tw_en = 1'b1; // Live at once for next fetch
          cnt_next = cnt_reg - 16'h0001;
          adr_next = adr_reg + 16'h0001;
          mem_next.req = 1'b0;
        end else if (!mem_reg.req) begin
          if (cnt_reg == 16'h0000) begin
            bml_next = '{1'b1, cnt_reg, adr_reg};
            st_next = S_IDLE;
          end else
            mem_next = '{1'b1, 1'b0, {5'h00, adr_reg[14:0]}, 16'h0000};
        end
      end
    endcase
    // Fault entry: drop the map and start the push
    if (flt) begin
      xl_next = 1'b0;
      uew_next = 1'b0;
      flt_next = 1'b1;
      stat_next[ST_IOF:ST_INDF] = cause[ST_IOF:ST_INDF];
      mem_next = '{1'b1, 1'b1, {4'h0, i_sp + 16'h0001}, i_acs[63:48]};
      frm_next = {i_acs[47:0], i_next_pc, 16'h0000};
      wc_next = 3'h0;
      st_next = S_PUSH;
    end
    // Level outputs follow the next state so they leave a flop
    irq_next = uew_next | sc_next;
    bsy_next = (st_next != S_IDLE);
  end

  // State registers; power up in unmapped mode
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_reg <= S_IDLE;  stat_reg <= ST_RESET;  xl_reg <= 1'b0;
      uew_reg <= 1'b0;  sc_reg <= 1'b0;  p31_reg <= PPAGE_31;
      chk_reg <= '0;  ind_reg <= '0;  wc_reg <= '0;  cnt_reg <= '0;
      adr_reg <= '0;  frm_reg <= '0;  mem_reg <= '0;  ac_reg <= '0;
      jmp_reg <= '0;  bml_reg <= '0;  flt_reg <= 1'b0;  lef_reg <= 1'b0;
      irq_reg <= 1'b0;  bsy_reg <= 1'b0;
    end else begin
      st_reg <= st_next;  stat_reg <= stat_next;  xl_reg <= xl_next;
      uew_reg <= uew_next;  sc_reg <= sc_next;  p31_reg <= p31_next;
      chk_reg <= chk_next;  ind_reg <= ind_next;  wc_reg <= wc_next;
      cnt_reg <= cnt_next;  adr_reg <= adr_next;  frm_reg <= frm_next;
      mem_reg <= mem_next;  ac_reg <= ac_next;  jmp_reg <= jmp_next;
      bml_reg <= bml_next;  flt_reg <= flt_next;  lef_reg <= lef_next;
      irq_reg <= irq_next;  bsy_reg <= bsy_next;
    end
  end

  // Tables hold no reset: contents start undefined
  always_ff @(posedge i_clock) begin
    if (tw_en)
      tbl[tw_t][tw_p] <= tw_d;
  end

  assign o_mem = mem_reg;
  assign o_ac = ac_reg;
  assign o_bml = bml_reg;
  assign o_jump = jmp_reg;
  assign o_fault = flt_reg;
  assign o_lef_exec = lef_reg;
  assign o_irq_inhibit = irq_reg;
  assign o_busy = bsy_reg;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_fault_unmaps: assert property (o_fault |-> !xl_reg && st_reg == S_PUSH && o_mem.we)
    else $error("fault left map on");
  a_push_five: assert property (st_reg == S_VEC |-> wc_reg == RET_WORDS)
    else $error("return block not five words");
  a_vec_read: assert property (st_reg == S_VEC && o_mem.req |-> o_mem.addr == FAULT_VEC && !o_mem.we)
    else $error("vector read wrong");
  a_high_write: assert property (o_mem.req && o_mem.we && st_reg == S_REF |-> o_mem.addr[19:18] == 2'b00)
    else $error("write past memory");
  a_lef_noexec: assert property (o_lef_exec |-> $stable(stat_reg) && !o_ac.valid)
    else $error("converted op acted");
  a_io_reset: assert property (cmd_go && i_cmd.op == OP_IO_RESET |=> !xl_reg && p31_reg == PPAGE_31 && !stat_reg[ST_DCH])
    else $error("io reset incomplete");
  a_load_prot: assert property (st_reg == S_IDLE && i_cmd.valid && i_cmd.op == OP_BLOCK_LOAD && xl_reg && stat_reg[ST_IOP] |=> o_fault && stat_reg[ST_IOF])
    else $error("protected load ran");
  a_load_end: assert property (o_bml.done |-> o_bml.ac1 == 16'h0000 && $past(st_reg) == S_LOAD)
    else $error("load count not zero");
  a_sc_off: assert property (st_reg == S_REF && i_mem_ack && sc_reg |=> !xl_reg && !sc_reg)
    else $error("single cycle kept map");
  c_fault: cover property (o_fault ##[1:40] o_jump.valid);
  c_load: cover property (o_bml.done && o_bml.ac2 != 16'h0000);
  c_lef: cover property (o_lef_exec);
endmodule : pmpu_top

// File: core/pmpu_pkg.sv
package pmpu_pkg;
  // Control instructions offered by the core
  typedef enum logic [3:0] {
    OP_NONE, OP_STATUS_LOAD, OP_STATUS_READ, OP_PAGE31_SET, OP_INIT_CHECK,
    OP_PAGE_CHECK, OP_SINGLE_CYCLE, OP_IO_RESET, OP_BLOCK_LOAD, OP_OTHER_IO
  } pmpu_op_e;
  // Status bit positions, vector index = 15 - printed bit
  localparam int ST_NME0 = 15;
  localparam int ST_MPN  = 14;
  localparam int ST_IOF  = 13;
  localparam int ST_WPF  = 12;
  localparam int ST_INDF = 11;
  localparam int ST_SC   = 10;
  localparam int ST_SELH = 9;
  localparam int ST_SELL = 7;
  localparam int ST_LEF  = 6;
  localparam int ST_IOP  = 5;
  localparam int ST_WP   = 4;
  localparam int ST_IND  = 3;
  localparam int ST_NME1 = 2;
  localparam int ST_DCH  = 1;
  localparam int ST_UE   = 0;
  localparam logic [15:0] ST_RESET    = 16'h0000;
  localparam logic [15:0] ST_IO_RESET_OP_KEEP = 16'h03f8; // Bits 6-12 survive
  // Table word layout
  localparam int TW_WP   = 15;
  localparam int TW_LPH  = 14;
  localparam int TW_LPL  = 10;
  localparam logic [4:0]  PAGE_31    = 5'h1f;
  localparam logic [9:0]  PPAGE_31   = 10'h01f;
  localparam logic [9:0]  PPAGE_LIM  = 10'h100; // 18-bit word space
  localparam logic [19:0] FAULT_VEC  = 20'h00003;
  localparam logic [2:0]  RET_WORDS  = 3'h5;
  localparam logic [3:0]  IND_LAST   = 4'hf;    // 16th level
  typedef struct packed {
    logic        valid;
    pmpu_op_e    op;
    logic [15:0] ac;
    logic [15:0] ac1;
    logic [15:0] ac2;
  } pmpu_cmd_s;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        indirect;
    logic        chan;
    logic [1:0]  chan_sel;
    logic [14:0] addr;
  } pmpu_ref_s;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [19:0] addr;
    logic [15:0] wdata;
  } pmpu_mem_s;
  typedef struct packed {
    logic        done;
    logic [15:0] ac1;
    logic [15:0] ac2;
  } pmpu_bml_s;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } pmpu_word_s;
endpackage : pmpu_pkg

// File: tb/pmpu_mem_model.sv
`timescale 1ns/1ps
// Word memory behind the block, with optional wait states
module pmpu_mem_model import pmpu_pkg::*; (
  input  wire logic      i_clock,
  input  wire pmpu_mem_s i_mem,
  input  wire logic      i_slow,
  output logic           o_ack,
  output logic [15:0]    o_rdata
);
  logic [15:0] mem [logic [19:0]]; // Sparse store, bench preloads it
  int          cnt = 0;            // Wait states already served
  initial begin
    o_ack   = 1'b0;
    o_rdata = 16'ha5a5;
  end
  // One ack per request; data toggles outside acks so stale reads show
  always @(posedge i_clock) begin
    o_ack   <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_mem.req && !o_ack) begin
      if (cnt >= (i_slow ? 3 : 0)) begin
        cnt   <= 0;
        o_ack <= 1'b1;
        if (i_mem.we) begin
          mem[i_mem.addr] = i_mem.wdata;
        end else begin
          o_rdata <= mem.exists(i_mem.addr) ? mem[i_mem.addr] : ~o_rdata;
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : pmpu_mem_model

// File: tb/pmpu_top_bench.sv
`timescale 1ns/1ps
// Driver notes expected events in a queue, monitor matches them in order
module pmpu_top_bench import pmpu_pkg::*; ;
  logic        i_clock   = 1'b0;
  logic        i_rst     = 1'b1;
  pmpu_cmd_s   i_cmd     = '0;
  pmpu_ref_s   i_ref     = '0;
  logic        i_ret_op  = 1'b0;
  logic [15:0] i_next_pc = 16'h0;
  logic [15:0] i_sp      = 16'h0200;
  logic [63:0] i_acs     = 64'h0;
  logic        mem_ack;
  logic [15:0] mem_rdata;
  logic        slow      = 1'b0;   // Memory wait states on or off
  logic        armed     = 1'b0;   // Current request already noted
  pmpu_mem_s   o_mem;
  pmpu_word_s  o_ac;
  pmpu_word_s  o_jump;
  pmpu_bml_s   o_bml;
  logic        o_fault;
  logic        o_lef_exec;
  logic        o_irq_inhibit;
  logic        o_busy;
  logic [39:0] q [$];              // Kind in top three bits
  int          bad_count = 0;
  int          samples_checked = 0;
  integer      seed = 32'hfa3d8382;

  pmpu_top u_dut (.i_clock, .i_rst, .i_cmd, .i_ref, .i_ret_op, .i_next_pc, .i_sp, .i_acs,
    .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_mem, .o_ac, .o_bml, .o_jump,
    .o_fault, .o_lef_exec, .o_irq_inhibit, .o_busy);
  pmpu_mem_model u_mem (.i_clock, .i_mem(o_mem), .i_slow(slow), .o_ack(mem_ack), .o_rdata(mem_rdata));

  always #50 i_clock = ~i_clock;

  task automatic check_val(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // Kind 7 marks a write whose data the bench cannot predict
  task automatic take(input logic [39:0] seen);
    logic [39:0] e;
    e = (q.size() > 0) ? q.pop_front() : '0;
    if (e[39:37] == 3'd7) seen = {3'd7, seen[36:16], 16'h0};
    check_val(seen, e);
  endtask : take

  // Monitor: an unexpected event meets the wrong note and fails
  always @(negedge i_clock) begin
    if (!i_rst) begin
      if (o_fault) take({3'd4, 37'h0});
      if (o_mem.req && !armed) take({3'd6, o_mem.we, o_mem.addr, (o_mem.we ? o_mem.wdata : 16'h0)});
      if (o_ac.valid) take({3'd1, 21'h0, o_ac.data});
      if (o_bml.done) take({3'd2, 5'h0, o_bml.ac1, o_bml.ac2});
      if (o_jump.valid) take({3'd3, 21'h0, o_jump.data});
      if (o_lef_exec) take({3'd5, 37'h0});
    end
    armed = o_mem.req && !mem_ack;
  end

  task automatic ex(input logic [2:0] k, input logic [36:0] p);
    q.push_back({k, p});
  endtask : ex

  // Bounded wait for the sequencer to go idle
  task automatic wait_idle();
    int n = 0;
    @(negedge i_clock);
    while (o_busy !== 1'b0 && n < 400) begin
      @(negedge i_clock);
      n++;
    end
    if (n == 400) bad_count++;
  endtask : wait_idle

  task automatic cmd(input pmpu_op_e o, input logic [15:0] a, input logic [15:0] c1 = 16'h0,
                     input logic [15:0] c2 = 16'h0);
    @(negedge i_clock);
    i_cmd = '{1'b1, o, a, c1, c2};
    @(negedge i_clock);
    i_cmd = '0;
    wait_idle();
  endtask : cmd

  task automatic mref(input logic w, input logic indirect_protect_flag, input logic ch, input logic [1:0] cs,
                      input logic [14:0] a);
    @(negedge i_clock);
    slow = 1'($random(seed));
    i_ref = '{1'b1, w, indirect_protect_flag, ch, cs, a};
    @(negedge i_clock);
    i_ref = '0;
    wait_idle();
  endtask : mref

  task automatic rd(input logic [15:0] v);
    ex(1, {21'h0, v});
    cmd(OP_STATUS_READ, 16'h0);
  endtask : rd

  task automatic rdat(input logic indirect_protect_flag, input logic [14:0] la, input logic [19:0] pa);
    ex(6, {1'b0, pa, 16'h0});
    mref(1'b0, indirect_protect_flag, 1'b0, 2'd0, la);
  endtask : rdat

  // Two table words from 0x100 upward; count ends 0, source past last word
  task automatic load_tbl(input logic [15:0] w0, input logic [15:0] w1);
    u_mem.mem[20'h00100] = w0;
    u_mem.mem[20'h00101] = w1;
    ex(6, {1'b0, 20'h00100, 16'h0});
    ex(6, {1'b0, 20'h00101, 16'h0});
    ex(2, {5'h0, 16'h0, 16'h0102});
    cmd(OP_BLOCK_LOAD, 16'h0, 16'h2, 16'h0100);
  endtask : load_tbl

  // Return block: AC0..AC3, next pc, then handler fetched via word 3
  task automatic exp_fault();
    ex(4, 37'h0);
    for (int i = 0; i < 4; i++) ex(6, {1'b1, 4'h0, i_sp + 16'(i + 1), i_acs[63 - 16 * i -: 16]});
    ex(6, {1'b1, 4'h0, i_sp + 16'h5, i_next_pc});
    ex(6, {1'b0, FAULT_VEC, 16'h0});
    ex(3, {21'h0, 16'h0777});
  endtask : exp_fault

  // Interrupts held off until a return-type instruction starts mapping
  task automatic map_on(input logic [15:0] v);
    cmd(OP_STATUS_LOAD, v);
    check_val({39'h0, o_irq_inhibit}, 40'h1);
    @(negedge i_clock);
    i_ret_op = 1'b1;
    @(negedge i_clock);
    i_ret_op = 1'b0;
    @(negedge i_clock);
    check_val({39'h0, o_irq_inhibit}, 40'h0);
  endtask : map_on

  initial begin
    repeat (60000) @(posedge i_clock);
    bad_count++;
    final_report();
  end

  initial begin
    logic [15:0] v;
    i_acs = {16'h0, 16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
    i_next_pc = 16'($random(seed));
    u_mem.mem[FAULT_VEC] = 16'h0777;
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
    rd(16'h0000);
    rdat(1'b0, 15'h7c05, 20'h07c05);
    repeat (4) begin
      v = 16'($random(seed)) & 16'h83fe;
      cmd(OP_STATUS_LOAD, v);
      rd(v);
    end
    for (int s = 0; s < 8; s++) begin
      cmd(OP_STATUS_LOAD, {6'h0, 3'(s), 7'h0});
      load_tbl({1'b0, 5'd2, 10'h040 + 10'(s)}, {1'b1, 5'd3, 10'h3ff});
      ex(1, {21'h0, 1'b0, 3'(s), 2'b00, 10'h040 + 10'(s)});
      cmd(OP_INIT_CHECK, {1'b0, 5'd2, 3'(s), 7'h0});
      cmd(OP_PAGE_CHECK, 16'h0);
    end
    cmd(OP_STATUS_LOAD, 16'h0);
    load_tbl({1'b1, 5'd4, 10'h050}, {1'b0, 5'd5, 10'h120});
    map_on(16'h0011);
    rd(16'h4011);
    rdat(1'b0, {5'd2, 10'h02a}, {10'h040, 10'h02a});
    mref(1'b1, 1'b0, 1'b0, 2'd0, {5'd5, 10'h001});
    exp_fault();
    mref(1'b1, 1'b0, 1'b0, 2'd0, {5'd4, 10'h003});
    cmd(OP_STATUS_LOAD, 16'h0);
    rd(16'h1000);
    map_on(16'h0001);
    exp_fault();
    mref(1'b0, 1'b0, 1'b0, 2'd0, {5'd3, 10'h004});
    cmd(OP_STATUS_LOAD, 16'h0);
    rd(16'h0000);
    map_on(16'h0009);
    for (int k = 0; k < 15; k++) rdat(1'b1, {5'd2, 10'(k)}, {10'h040, 10'(k)});
    exp_fault();
    mref(1'b0, 1'b1, 1'b0, 2'd0, {5'd2, 10'h00f});
    cmd(OP_STATUS_LOAD, 16'h0);
    rd(16'h0800);
    map_on(16'h0041);
    ex(5, 37'h0);
    cmd(OP_STATUS_READ, 16'h0);
    load_tbl({1'b0, 5'd6, 10'h070}, {1'b0, 5'd7, 10'h071});
    rdat(1'b0, {5'd6, 10'h009}, {10'h070, 10'h009});
    exp_fault();
    mref(1'b0, 1'b0, 1'b0, 2'd0, {5'd3, 10'h000});
    map_on(16'h0021);
    exp_fault();
    cmd(OP_BLOCK_LOAD, 16'h0, 16'h2, 16'h0100);
    cmd(OP_STATUS_LOAD, 16'h0);
    rd(16'h2000);
    cmd(OP_STATUS_LOAD, 16'h83fe);
    ex(7, {1'b1, 10'h045, 10'h011, 16'h0});
    mref(1'b1, 1'b0, 1'b1, 2'd2, {5'd2, 10'h011});
    cmd(OP_PAGE31_SET, {6'h0, 10'h090});
    rdat(1'b0, 15'h7c05, {10'h090, 10'h005});
    cmd(OP_IO_RESET, 16'h0);
    rd(16'h03f8);
    rdat(1'b0, 15'h7c05, 20'h07c05);
    ex(7, {1'b1, 20'h00811, 16'h0});
    mref(1'b1, 1'b0, 1'b1, 2'd2, {5'd2, 10'h011});
    cmd(OP_SINGLE_CYCLE, 16'h0);
    check_val({39'h0, o_irq_inhibit}, 40'h1);
    rdat(1'b0, {5'd2, 10'h033}, {10'h040, 10'h033});
    rdat(1'b0, {5'd2, 10'h033}, 20'h00833);
    // User C then user B through single-cycle mapping
    cmd(OP_STATUS_LOAD, 16'h0004);
    cmd(OP_SINGLE_CYCLE, 16'h0);
    rdat(1'b0, {5'd2, 10'h033}, {10'h042, 10'h033});
    cmd(OP_STATUS_LOAD, 16'h8000);
    cmd(OP_SINGLE_CYCLE, 16'h0);
    rdat(1'b0, {5'd2, 10'h033}, {10'h041, 10'h033});
    repeat (5) @(negedge i_clock);
    check_val(40'(q.size()), 40'h0);
    final_report();
  end
endmodule : pmpu_top_bench
